// ==== rtl/qur_top.sv ====
// Quad serial port with strap-dependent reset and AXI4-Lite registers.
// Contract
// [R1] Strap high: reset pin active high; a 40 ns pulse resets everything. The pin resets only the channels; the AXI interface resets on aresetn alone.
// [R2] During reset each channel drives transmit high and ignores receive.
// [R3] Strap low: reset pin active low; a 40 ns pulse resets everything. The pin resets only the channels; the AXI interface resets on aresetn alone.
// [R4] Four channels, each with its own configuration, status, data registers.
// [R5] Each channel has 64-byte transmit and 64-byte receive FIFOs.
// [R6] Prescaler pin picks divide by one or four before baud generator.
// [R7] Modem control bit 7 overrides the pin's prescaler choice.
// [R8] Modem control bit 5 lets any received character resume Xoff halt.
// [R9] In 16 mode, style pin and control bit 3 enable interrupt outputs.
// [R10] Receiver supports 4x oversampling for high data rates.
// [R11] One summary register shows all ready flags of all channels live.
// [R12] Baud generator has a fractional divisor after the prescaler.
// [R13] Prescaler pin is sampled only in reset; high divides by one.
// [R14] System drives strap high for 16 mode, low for 68 mode.
// [R15] Reset release is synchronised before channel logic restarts.
module qur_top import qur_pkg::*; (
    input wire logic aclk, // 250 MHz clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic reset_pin, // device reset, polarity set by strap
    input wire logic bus_style_strap, // high 16 mode, low 68 mode
    input wire logic interrupt_output_style_pin, // high continuous
    input wire logic baud_prescaler_select_pin, // high div 1, low div 4
    input wire logic [NCH-1:0] rxd, // serial receive inputs
    output logic [NCH-1:0] txd, // serial transmit outputs
    output logic [NCH-1:0] transmit_ready_n, // low: room in tx FIFO
    output logic [NCH-1:0] receive_ready_n, // low: data in rx FIFO
    output logic [NCH-1:0] irq, // interrupt level, active high
    output logic [NCH-1:0] irq_oe // interrupt output enable
);
    logic [7:0] sync1_q, sync2_q;
    logic rst_s, strap_s, style_s, presc_s;
    logic [NCH-1:0] rxd_s;
    logic ch_rst_q, ch_rst_d;
    logic awready_q, awready_d, bvalid_q, bvalid_d;
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [NCH-1:0] txd_q, trdy_n_q, rrdy_n_q, irq_q, irq_oe_q;
    logic [NCH-1:0] halt_q, rx_done;
    logic [7:0] mcr_q [NCH];
    logic [7:0] cfg_q [NCH];
    logic [15:0] div_q [NCH];
    logic [7:0] stat [NCH];
    logic [7:0] rx_head [NCH];
    logic [6:0] tcnt_q [NCH];
    logic [1:0] w_ch, r_ch;
    logic [4:0] w_off, r_off;
    logic w_ok;

    // Every pin from outside the clock domain passes two flops.
    always_ff @(posedge aclk) begin
        sync1_q <= {reset_pin, bus_style_strap, interrupt_output_style_pin,
                    baud_prescaler_select_pin, rxd};
        sync2_q <= sync1_q;
    end
    assign {rst_s, strap_s, style_s, presc_s, rxd_s} = sync2_q;

    // Polarity follows the strap; a single synchronised sample resets.
    always_comb begin
        ch_rst_d = ~aresetn | (strap_s ? rst_s : ~rst_s); // [R1] [R3] [R14]
    end
    always_ff @(posedge aclk) begin
        ch_rst_q <= ch_rst_d; // [R15]
    end

    assign w_ch = s_axi_awaddr[6:5];
    assign w_off = s_axi_awaddr[4:0];
    assign r_ch = s_axi_araddr[6:5];
    assign r_off = s_axi_araddr[4:0];
    assign w_ok = (s_axi_awaddr == REG_SUMMARY) | (~s_axi_awaddr[7] &
        (w_off == REG_DATA | w_off == REG_STAT | w_off == REG_MCR |
         w_off == REG_DIV | w_off == REG_CFG));

    // Address and data are taken together, so one flop drives both readies.
    always_comb begin
        awready_d = s_axi_awvalid & s_axi_wvalid & ~awready_q & ~bvalid_q;
        bvalid_d = bvalid_q ? ~s_axi_bready : awready_q;
        bresp_d = bresp_q;
        if (awready_q) begin
            bresp_d = w_ok ? RESP_OKAY : RESP_SLVERR;
        end
        arready_d = s_axi_arvalid & ~arready_q & ~rvalid_q;
        rvalid_d = rvalid_q ? ~s_axi_rready : arready_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (arready_q) begin
            rresp_d = RESP_OKAY;
            rdata_d = 32'h0;
            if (s_axi_araddr == REG_SUMMARY) begin
                rdata_d = {24'h0, rrdy_n_q, trdy_n_q}; // [R11]
            end else if (!s_axi_araddr[7]) begin
                case (r_off)
                    REG_DATA: rdata_d = {24'h0, rx_head[r_ch]};
                    REG_STAT: rdata_d = {24'h0, stat[r_ch]};
                    REG_MCR: rdata_d = {24'h0, mcr_q[r_ch]};
                    REG_DIV: rdata_d = {16'h0, div_q[r_ch]};
                    REG_CFG: rdata_d = {24'h0, cfg_q[r_ch]};
                    default: rresp_d = RESP_SLVERR;
                endcase
            end else begin
                rresp_d = RESP_SLVERR;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0;
        end else begin
            awready_q <= awready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end
    assign s_axi_awready = awready_q;
    assign s_axi_wready = awready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign txd = txd_q;
    assign transmit_ready_n = trdy_n_q;
    assign receive_ready_n = rrdy_n_q;
    assign irq = irq_q;
    assign irq_oe = irq_oe_q;

    for (genvar i = 0; i < NCH; i++) begin : g_ch // [R4]
        logic [7:0] tx_mem [FIFO_DEPTH];
        logic [7:0] rx_mem [FIFO_DEPTH];
        logic [5:0] twp_q, twp_d, trp_q, trp_d, rwp_q, rwp_d, rrp_q, rrp_d;
        logic [6:0] tcnt_d, rcnt_q, rcnt_d;
        logic [7:0] mcr_d, cfg_d, rsh_q, rsh_d;
        logic [15:0] div_d, dcnt_q, dcnt_d;
        logic [1:0] pre_q, pre_d;
        logic [3:0] acc_q, acc_d, os_max;
        logic [3:0] tos_q, tos_d, tbit_q, tbit_d, ros_q, ros_d, rbit_q, rbit_d;
        logic [9:0] tsh_q, tsh_d;
        qur_line_t tst_q, tst_d, rst_q, rst_d;
        logic tick, sel, tpush, tpop, rpush, rpop, flow;
        logic halt_d, ovr_q, ovr_d, txd_d, ovr_clr;
        logic [4:0] frac_sum;

        assign sel = ~s_axi_awaddr[7] & w_ch == i & awready_q;
        assign tpush = sel & w_off == REG_DATA & s_axi_wstrb[0] &
                       tcnt_q[i] != FIFO_FULL;
        assign rpop = arready_q & ~s_axi_araddr[7] & r_ch == i &
                      r_off == REG_DATA & rcnt_q != 7'h0;
        assign ovr_clr = arready_q & ~s_axi_araddr[7] & r_ch == i &
                         r_off == REG_STAT;
        assign os_max = cfg_q[i][CFG_OS4] ? OS4_MAX : OS16_MAX; // [R10]
        assign tick = pre_q == 2'h0 && dcnt_q <= 16'h1;
        assign frac_sum = {1'b0, acc_q} + {1'b0, cfg_q[i][3:0]};
        assign flow = cfg_q[i][CFG_SWFC] &
                      (rsh_q == XON_CHAR | rsh_q == XOFF_CHAR);
        assign tpop = tst_q == QUR_IDLE & tick & tcnt_q[i] != 7'h0 &
                      ~halt_q[i];
        assign rpush = rx_done[i] & ~flow & rcnt_q != FIFO_FULL;
        assign rx_done[i] = rst_q == QUR_SHIFT & tick &
                            ros_q == {1'b0, os_max[3:1]} &
                            rbit_q == LAST_BIT & rxd_s[i];
        assign rx_head[i] = rx_mem[rrp_q];
        assign stat[i] = {halt_q[i], tst_q == QUR_IDLE && tcnt_q[i] == 7'h0,
                          tcnt_q[i] != FIFO_FULL, 3'h0, ovr_q,
                          rcnt_q != 7'h0};

        always_comb begin
            mcr_d = mcr_q[i];
            cfg_d = cfg_q[i];
            div_d = div_q[i];
            if (sel && w_off == REG_MCR && s_axi_wstrb[0]) begin
                mcr_d = s_axi_wdata[7:0]; // [R7]
            end
            if (sel && w_off == REG_CFG && s_axi_wstrb[0]) begin
                cfg_d = s_axi_wdata[7:0];
            end
            if (sel && w_off == REG_DIV) begin
                if (s_axi_wstrb[0]) div_d[7:0] = s_axi_wdata[7:0];
                if (s_axi_wstrb[1]) div_d[15:8] = s_axi_wdata[15:8];
            end
            // Prescaler stage, then integer count plus fractional carry.
            pre_d = (pre_q == 2'h0) ?
                (mcr_q[i][MCR_PRESC4] ? PRESC4_MAX : 2'h0) : pre_q - 2'h1; // [R6]
            dcnt_d = dcnt_q;
            acc_d = acc_q;
            if (pre_q == 2'h0) begin
                if (tick) begin
                    acc_d = frac_sum[3:0];
                    dcnt_d = div_q[i] + {15'h0, frac_sum[4]}; // [R12]
                end else begin
                    dcnt_d = dcnt_q - 16'h1;
                end
            end
            twp_d = tpush ? twp_q + 6'h1 : twp_q;
            trp_d = tpop ? trp_q + 6'h1 : trp_q;
            tcnt_d = tcnt_q[i] + {6'h0, tpush} - {6'h0, tpop}; // [R5]
            rwp_d = rpush ? rwp_q + 6'h1 : rwp_q;
            rrp_d = rpop ? rrp_q + 6'h1 : rrp_q;
            rcnt_d = rcnt_q + {6'h0, rpush} - {6'h0, rpop}; // [R5]
            // An overrun in the same cycle as the clearing read survives.
            ovr_d = (ovr_q & ~ovr_clr) | (rx_done[i] & ~flow &
                    rcnt_q == FIFO_FULL);
            halt_d = halt_q[i];
            if (rx_done[i] && cfg_q[i][CFG_SWFC]) begin
                if (rsh_q == XOFF_CHAR) halt_d = 1'b1;
                else if (rsh_q == XON_CHAR || mcr_q[i][MCR_ANY_XON])
                    halt_d = 1'b0; // [R8]
            end
            tst_d = tst_q;
            tos_d = tos_q;
            tbit_d = tbit_q;
            tsh_d = tsh_q;
            if (tpop) begin
                tst_d = QUR_SHIFT;
                tsh_d = {1'b1, tx_mem[trp_q], 1'b0};
                tos_d = 4'h0;
                tbit_d = 4'h0;
            end else if (tst_q == QUR_SHIFT && tick) begin
                tos_d = tos_q + 4'h1;
                if (tos_q == os_max) begin
                    tos_d = 4'h0;
                    tsh_d = {1'b1, tsh_q[9:1]};
                    tbit_d = tbit_q + 4'h1;
                    if (tbit_q == LAST_BIT) tst_d = QUR_IDLE;
                end
            end
            txd_d = tst_q == QUR_SHIFT ? tsh_q[0] : 1'b1;
            rst_d = rst_q;
            ros_d = ros_q;
            rbit_d = rbit_q;
            rsh_d = rsh_q;
            case (rst_q)
                QUR_IDLE: begin
                    if (tick && !rxd_s[i]) begin
                        rst_d = QUR_SHIFT;
                        ros_d = 4'h0;
                        rbit_d = 4'h0;
                    end
                end
                QUR_SHIFT: begin
                    if (tick) begin
                        ros_d = (ros_q == os_max) ? 4'h0 : ros_q + 4'h1;
                        if (ros_q == os_max) rbit_d = rbit_q + 4'h1;
                        // Mid-bit sample; a high start bit is a glitch.
                        if (ros_q == {1'b0, os_max[3:1]}) begin
                            if (rbit_q == 4'h0 && rxd_s[i]) rst_d = QUR_IDLE;
                            else if (rbit_q == LAST_BIT) rst_d = QUR_IDLE;
                            else if (rbit_q != 4'h0)
                                rsh_d = {rxd_s[i], rsh_q[7:1]};
                        end
                    end
                end
                default: rst_d = QUR_IDLE;
            endcase
        end

        always_ff @(posedge aclk) begin
            if (tpush) tx_mem[twp_q] <= s_axi_wdata[7:0];
            if (rpush) rx_mem[rwp_q] <= rsh_q;
        end
        always_ff @(posedge aclk) begin
            if (ch_rst_q) begin
                mcr_q[i] <= {~presc_s, MCR_RST[6:0]}; // [R13]
                cfg_q[i] <= CFG_RST;
                div_q[i] <= DIV_RST;
                {twp_q, trp_q, rwp_q, rrp_q} <= 24'h0;
                tcnt_q[i] <= 7'h0;
                rcnt_q <= 7'h0;
                {pre_q, acc_q, dcnt_q} <= 22'h0;
                {ovr_q, halt_q[i]} <= 2'h0;
                tst_q <= QUR_IDLE;
                rst_q <= QUR_IDLE; // [R2]
                {tos_q, tbit_q, ros_q, rbit_q} <= 16'h0;
                tsh_q <= 10'h3ff;
                rsh_q <= 8'h00;
                txd_q[i] <= 1'b1; // [R2]
                trdy_n_q[i] <= 1'b1;
                rrdy_n_q[i] <= 1'b1;
                irq_q[i] <= 1'b0;
                irq_oe_q[i] <= 1'b0;
            end else begin
                mcr_q[i] <= mcr_d;
                cfg_q[i] <= cfg_d;
                div_q[i] <= div_d;
                {twp_q, trp_q, rwp_q, rrp_q} <= {twp_d, trp_d, rwp_d, rrp_d};
                tcnt_q[i] <= tcnt_d;
                rcnt_q <= rcnt_d;
                {pre_q, acc_q, dcnt_q} <= {pre_d, acc_d, dcnt_d};
                {ovr_q, halt_q[i]} <= {ovr_d, halt_d};
                tst_q <= tst_d;
                rst_q <= rst_d;
                {tos_q, tbit_q, ros_q, rbit_q} <= {tos_d, tbit_d, ros_d, rbit_d};
                tsh_q <= tsh_d;
                rsh_q <= rsh_d;
                txd_q[i] <= txd_d;
                trdy_n_q[i] <= tcnt_d == FIFO_FULL; // [R11]
                rrdy_n_q[i] <= rcnt_d == 7'h0; // [R11]
                irq_q[i] <= rcnt_d != 7'h0 || tcnt_d == 7'h0;
                // 68 mode keeps the outputs enabled whenever the channel is out of reset.
                irq_oe_q[i] <= ~strap_s | style_s | mcr_d[MCR_INT_EN]; // [R9]
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        awready_q && s_axi_awvalid && s_axi_wvalid;
    endsequence
    sequence s_sum_read;
        arready_q && s_axi_araddr == REG_SUMMARY;
    endsequence
    AST_HI_RESET: assert property (strap_s && rst_s |=> ch_rst_q) // [R1]
        else $error("Active-high reset not applied.");
    AST_LO_RESET: assert property (!strap_s && !rst_s |=> ch_rst_q) // [R3]
        else $error("Active-low reset not applied.");
    AST_TX_HELD: assert property (ch_rst_q [*2] |-> txd_q == 4'hf) // [R2]
        else $error("Transmit line not high during reset.");
    AST_PRESC_SAMPLE: assert property (ch_rst_q |=>
        mcr_q[0][MCR_PRESC4] == !$past(presc_s)) // [R13]
        else $error("Prescaler pin not captured at reset.");
    AST_SUMMARY: assert property (s_sum_read |=>
        rdata_q[7:0] == $past({rrdy_n_q, trdy_n_q})) // [R11]
        else $error("Summary read does not match ready flags.");
    AST_FIFO_BOUND: assert property (tcnt_q[0] <= FIFO_FULL) // [R5]
        else $error("Transmit FIFO count beyond 64.");
    AST_INT_STYLE: assert property (!ch_rst_q && strap_s && style_s
        |=> irq_oe_q == 4'hf) // [R9]
        else $error("Continuous interrupt style not enabled.");
    AST_ANY_RESUME: assert property (!ch_rst_q && rx_done[0] &&
        cfg_q[0][CFG_SWFC] && mcr_q[0][MCR_ANY_XON] &&
        g_ch[0].rsh_q != XOFF_CHAR |=> !halt_q[0]) // [R8]
        else $error("Any character did not resume transmit.");
    AST_WR_RESP: assert property (s_wr_taken |=> bvalid_q [*1]) // [R4]
        else $error("Write response missing one cycle after write.");
endmodule

// ==== rtl/qur_pkg.sv ====
// Shared constants and types for the quad serial port block.
package qur_pkg;
    localparam int NCH = 4;
    localparam int FIFO_DEPTH = 64;
    localparam logic [6:0] FIFO_FULL = 7'h40;
    // Register map: channel n sits at n * 0x20, summary at 0x80.
    localparam logic [4:0] REG_DATA = 5'h00;
    localparam logic [4:0] REG_STAT = 5'h04;
    localparam logic [4:0] REG_MCR = 5'h08;
    localparam logic [4:0] REG_DIV = 5'h0c;
    localparam logic [4:0] REG_CFG = 5'h10;
    localparam logic [7:0] REG_SUMMARY = 8'h80;
    // Modem control bits.
    localparam int MCR_INT_EN = 3;
    localparam int MCR_ANY_XON = 5;
    localparam int MCR_PRESC4 = 7;
    // Line configuration bits; low nibble is the divisor fraction.
    localparam int CFG_OS4 = 4;
    localparam int CFG_SWFC = 5;
    localparam logic [7:0] MCR_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [15:0] DIV_RST = 16'h0001;
    localparam logic [7:0] XON_CHAR = 8'h11;
    localparam logic [7:0] XOFF_CHAR = 8'h13;
    localparam logic [3:0] OS16_MAX = 4'hf;
    localparam logic [3:0] OS4_MAX = 4'h3;
    localparam logic [1:0] PRESC4_MAX = 2'h3;
    localparam logic [3:0] LAST_BIT = 4'h9;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic {QUR_IDLE, QUR_SHIFT} qur_line_t;
endpackage

// ==== test/qur_serial_partner.sv ====
// Serial device model on the line side of channel 0.
module qur_serial_partner (
    input wire logic aclk, // bench clock
    input wire logic line_in, // transmit line of the device
    output logic line_out // receive line of the device
);
    timeunit 1ns;
    timeprecision 1ps;
    int bit_cycles = 16;
    int low_run = 0;
    int run = 0;
    int frames = 0;
    logic [7:0] last_byte = 8'h00;
    initial line_out = 1'b1;
    // Frames are 8N1, least significant bit first; idle is high.
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out <= f[i];
            repeat (bit_cycles) @(posedge aclk);
        end
    endtask
    // The length of the last low stretch, in clock cycles, is kept in low_run.
    always @(posedge aclk) begin
        if (line_in === 1'b0) begin
            run = run + 1;
        end else begin
            if (run != 0) low_run = run;
            run = 0;
        end
    end
    initial begin
        forever begin
            @(posedge aclk);
            if (line_in === 1'b0) begin
                repeat (bit_cycles / 2) @(posedge aclk);
                for (int i = 0; i < 8; i++) begin
                    repeat (bit_cycles) @(posedge aclk);
                    last_byte[i] = line_in;
                end
                repeat (bit_cycles) @(posedge aclk);
                frames = frames + 1;
            end
        end
    end
endmodule

// ==== test/testbench.sv ====
// Register and serial line tests of the quad serial port.
module testbench import qur_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, reset_pin, bus_style_strap;
    logic interrupt_output_style_pin, baud_prescaler_select_pin, ser_line;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, rxd, txd, transmit_ready_n, receive_ready_n;
    logic [3:0] irq, irq_oe;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int errors = 0;
    int tests_run = 0;
    assign rxd = {3'b111, ser_line};
    qur_top qur_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reset_pin,
        .bus_style_strap, .interrupt_output_style_pin,
        .baud_prescaler_select_pin, .rxd, .txd, .transmit_ready_n,
        .receive_ready_n, .irq, .irq_oe);
    qur_serial_partner qur_serial_partner_inst (.aclk, .line_in(txd[0]),
        .line_out(ser_line));
    task automatic print_verdict;
        if (errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [7:0] ad(input int c, input logic [4:0] r);
        return 8'(c * 32) | 8'(r);
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", RESP_OKAY, s_axi_bresp);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] r, input string n);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(n, e, s_axi_rdata);
        chk({n, " resp"}, r, s_axi_rresp);
    endtask
    // Drives the reset pin to its active level for 10 cycles.
    task automatic pulse_pin(input logic act);
        @(posedge aclk);
        reset_pin <= act;
        repeat (5) @(posedge aclk);
        chk("txd in reset", 4'hf, txd);
        chk("tx ready in reset", 4'hf, transmit_ready_n);
        repeat (5) @(posedge aclk);
        reset_pin <= ~act;
        repeat (8) @(posedge aclk);
    endtask
    // Sends 0x00 so the low stretch is start plus eight bits.
    task automatic txrun(input int bc, input int e);
        int f;
        f = qur_serial_partner_inst.frames;
        qur_serial_partner_inst.bit_cycles = bc;
        wr(ad(0, REG_DATA), 32'h00);
        wait (qur_serial_partner_inst.frames == f + 1);
        chk("low run", 9 * bc, qur_serial_partner_inst.low_run);
        chk("tx byte", e, qur_serial_partner_inst.last_byte);
    endtask
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    initial begin
        repeat (40000) @(posedge aclk);
        errors++;
        print_verdict();
    end
    initial begin
        int f;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, reset_pin} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        bus_style_strap = 1'b1;
        interrupt_output_style_pin = 1'b0;
        baud_prescaler_select_pin = 1'b1;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
        chk("rx ready", 4'hf, receive_ready_n);
        chk("irq idle", 4'hf, irq);
        rd(REG_SUMMARY, 32'hf0, RESP_OKAY, "summary");
        for (int c = 0; c < NCH; c++) begin
            rd(ad(c, REG_MCR), 32'h00, RESP_OKAY, "mcr");
            rd(ad(c, REG_DIV), 32'h01, RESP_OKAY, "div");
            rd(ad(c, REG_STAT), 32'h60, RESP_OKAY, "stat");
        end
        rd(8'h84, 32'h00, RESP_SLVERR, "unmapped");
        wr(REG_SUMMARY, 32'hff);
        rd(REG_SUMMARY, 32'hf0, RESP_OKAY, "summary ro");
        wr(ad(1, REG_MCR), 32'h08);
        repeat (6) @(posedge aclk);
        chk("irq oe soft", 4'h2, irq_oe);
        interrupt_output_style_pin <= 1'b1;
        repeat (6) @(posedge aclk);
        chk("irq oe cont", 4'hf, irq_oe);
        interrupt_output_style_pin <= 1'b0;
        wr(ad(1, REG_MCR), 32'h00);
        qur_serial_partner_inst.send(8'ha5);
        repeat (20) @(posedge aclk);
        rd(REG_SUMMARY, 32'he0, RESP_OKAY, "summary rx");
        rd(ad(0, REG_DATA), 32'ha5, RESP_OKAY, "rx data");
        wr(ad(0, REG_CFG), 32'h10);
        qur_serial_partner_inst.bit_cycles = 4;
        qur_serial_partner_inst.send(8'h3c);
        repeat (8) @(posedge aclk);
        rd(ad(0, REG_DATA), 32'h3c, RESP_OKAY, "rx 4x");
        wr(ad(0, REG_CFG), 32'h00);
        txrun(16, 0);
        wr(ad(0, REG_CFG), 32'h08);
        txrun(24, 0);
        wr(ad(0, REG_CFG), 32'h00);
        wr(ad(0, REG_MCR), 32'h80);
        txrun(64, 0);
        wr(ad(0, REG_MCR), 32'h00);
        wr(ad(0, REG_CFG), 32'h20);
        qur_serial_partner_inst.bit_cycles = 16;
        qur_serial_partner_inst.send(XOFF_CHAR);
        repeat (20) @(posedge aclk);
        rd(ad(0, REG_STAT), 32'he0, RESP_OKAY, "stat halted");
        for (int i = 0; i < FIFO_DEPTH - 1; i++) wr(ad(0, REG_DATA), 32'h55);
        repeat (2) @(posedge aclk);
        chk("tx room", 1'b0, transmit_ready_n[0]);
        wr(ad(0, REG_DATA), 32'h55);
        repeat (2) @(posedge aclk);
        chk("tx full", 1'b1, transmit_ready_n[0]);
        wr(ad(0, REG_MCR), 32'h20);
        f = qur_serial_partner_inst.frames;
        qur_serial_partner_inst.send(8'h41);
        wait (qur_serial_partner_inst.frames == f + 1);
        chk("resumed", 8'h55, qur_serial_partner_inst.last_byte);
        baud_prescaler_select_pin <= 1'b0;
        repeat (4) @(posedge aclk);
        rd(ad(0, REG_MCR), 32'h20, RESP_OKAY, "mcr live pin");
        pulse_pin(1'b1);
        chk("tx cleared", 4'h0, transmit_ready_n);
        rd(ad(0, REG_MCR), 32'h80, RESP_OKAY, "mcr pin");
        rd(ad(0, REG_STAT), 32'h60, RESP_OKAY, "stat reset");
        reset_pin <= 1'b1;
        repeat (2) @(posedge aclk);
        bus_style_strap <= 1'b0;
        repeat (8) @(posedge aclk);
        wr(ad(3, REG_MCR), 32'h08);
        pulse_pin(1'b0);
        rd(ad(3, REG_MCR), 32'h80, RESP_OKAY, "mcr 68");
        print_verdict();
    end
endmodule
